// >>> logic/aiamc_pkg.sv
`default_nettype none

// Shared constants of the per-axis mode configuration block.
package aiamc_pkg;
	// Mode register selector values on the write port.
	localparam logic SEL_MODE2 = 1'h0;
	localparam logic SEL_MODE3 = 1'h1;
	// Reset values.
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [3:0] AXIS_SEL_RESET = 4'h1;
	// Limit, pulse and encoder mode register field positions.
	localparam int B_SOFT_PLUS_EN = 0;
	localparam int B_SOFT_MINUS_EN = 1;
	localparam int B_HARD_STOP_TYPE = 2;
	localparam int B_HARD_PLUS_POL = 3;
	localparam int B_HARD_MINUS_POL = 4;
	localparam int B_COMPARE_SRC = 5;
	localparam int B_PULSE_TYPE = 6;
	localparam int B_PULSE_POL = 7;
	localparam int B_DIR_POL = 8;
	localparam int B_ENC_TYPE = 9;
	localparam int B_QDIV_LO = 10;
	localparam int B_QDIV_HI = 11;
	localparam int B_ALARM_POL = 12;
	localparam int B_ALARM_EN = 13;
	localparam int B_INPOS_POL = 14;
	localparam int B_INPOS_EN = 15;
	// Acceleration and output mode register field positions.
	localparam int B_MANUAL_DECEL = 0;
	localparam int B_SEP_DECEL = 1;
	localparam int B_SCURVE = 2;
	localparam int B_EXTOP_LO = 3;
	localparam int B_EXTOP_HI = 4;
	localparam int B_STATUS_OUT_SEL = 7;
	localparam int B_GPO_LO = 8;
	localparam int B_GPO_HI = 11;
	// Bits software must keep at zero in the acceleration register.
	localparam logic [15:0] MODE3_ZERO_MASK = 16'hF060;
	// Quadrature division codes.
	localparam logic [1:0] QDIV_1 = 2'h0;
	localparam logic [1:0] QDIV_2 = 2'h1;
	localparam logic [1:0] QDIV_4 = 2'h2;
	// External operation modes.
	typedef enum logic [1:0] {
		AIAMC_EXT_OFF = 2'b00,
		AIAMC_EXT_CONT = 2'b01,
		AIAMC_EXT_FIXED = 2'b10,
		AIAMC_EXT_MPG = 2'b11
	} aiamc_ext_e;
endpackage : aiamc_pkg

`default_nettype wire

// >>> logic/aiamc_axis_mode.sv
// Operation
// - Per-axis mode copies, written to selected axes.
// - Plus soft limit decelerates, flags, refuses plus.
// - Minus soft limit decelerates, flags, refuses minus.
// - Hard limit stops sudden or decelerating.
// - Hard limit inputs have polarity bits.
// - Compare source logical or real counter.
// - Two-pulse type splits directions over pins.
// - Pulse-direction type: pulses plus direction pin.
// - Pulse polarity positive or negative logic.
// - Direction pin level follows polarity bit.
// - Quadrature decoding counts up when A leads.
// - Up/down input counts on rising edges.
// - Quadrature division one, half, quarter.
// - Enabled servo alarm flags and stops driving.
// - In-position holds driving flag until active.
// - Limit/pulse/encoder register resets to zero.
// - Automatic or manual deceleration selection.
// - Symmetric or separate deceleration rate.
// - Trapezoidal or S-curve profile selection.
// - External input operation mode decoding.
// - Acceleration register resets zero, reserved zero.
`default_nettype none

module aiamc_axis_mode
	import aiamc_pkg::*;
#(
	parameter int AXES = 4,
	parameter int POS_W = 32
) (
	input wire logic clock, // System clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic axis_select_command, // No-operation select strobe.
	input wire logic [AXES-1:0] sel_axes, // Axes named by the select.
	input wire logic wr_en, // Mode register write strobe.
	input wire logic wr_reg_sel, // 0 limit/pulse, 1 accel register.
	input wire logic [15:0] wr_data, // Mode register write data.
	input wire logic error_clear, // Clears the error status flags.
	input wire logic [AXES-1:0][POS_W-1:0] logical_pos, // Logical counts.
	input wire logic [AXES-1:0][POS_W-1:0] comp_plus, // Plus compare.
	input wire logic [AXES-1:0][POS_W-1:0] comp_minus, // Minus compare.
	input wire logic [AXES-1:0] drive_busy, // Pulse generator running.
	input wire logic [AXES-1:0] drive_dir_minus, // 1 while driving minus.
	input wire logic [AXES-1:0] drive_pulse, // Raw pulse, high active.
	input wire logic [AXES-1:0] drive_cmd_plus, // Plus drive command.
	input wire logic [AXES-1:0] drive_cmd_minus, // Minus drive command.
	input wire logic [AXES-1:0] hard_limit_plus_in, // Plus limit pin.
	input wire logic [AXES-1:0] hard_limit_minus_in, // Minus limit pin.
	input wire logic [AXES-1:0] servo_alarm_in, // Servo alarm pin.
	input wire logic [AXES-1:0] in_position_in, // In-position pin.
	input wire logic [AXES-1:0] encoder_a_in, // Encoder A or up pin.
	input wire logic [AXES-1:0] encoder_b_in, // Encoder B or down pin.
	input wire logic [AXES-1:0] external_plus_in, // External plus pin.
	input wire logic [AXES-1:0] external_minus_in, // External minus pin.
	output logic [AXES-1:0] pulse_plus_out, // Plus or pulse pin.
	output logic [AXES-1:0] pulse_minus_or_dir_out, // Minus or dir pin.
	output logic [AXES-1:0][POS_W-1:0] real_pos, // Real position counts.
	output logic [AXES-1:0] drive_start_plus, // Accepted plus command.
	output logic [AXES-1:0] drive_start_minus, // Accepted minus command.
	output logic [AXES-1:0] decel_stop, // Decelerating stop request.
	output logic [AXES-1:0] sudden_stop, // Immediate stop request.
	output logic [AXES-1:0] soft_limit_plus_flag, // Plus soft limit hit.
	output logic [AXES-1:0] soft_limit_minus_flag, // Minus soft limit hit.
	output logic [AXES-1:0] alarm_flag, // Servo alarm seen.
	output logic [AXES-1:0] axis_driving_flag, // Drive status per axis.
	output logic [AXES-1:0] manual_decel_sel, // 1 manual deceleration.
	output logic [AXES-1:0] separate_decel_rate_sel, // 1 non-symmetric.
	output logic [AXES-1:0] scurve_profile_sel, // 1 S-curve profile.
	output logic [AXES-1:0][1:0] external_operation_mode, // External mode.
	output logic [AXES-1:0] status_output_sel, // Status output select.
	output logic [AXES-1:0][3:0] general_out, // General output levels.
	output logic [AXES-1:0] ext_cont_plus, // External continuous plus.
	output logic [AXES-1:0] ext_cont_minus, // External continuous minus.
	output logic [AXES-1:0] ext_fixed_plus, // External fixed plus start.
	output logic [AXES-1:0] ext_fixed_minus // External fixed minus start.
);

	logic [AXES-1:0] axis_sel_reg; // Axes that receive writes.
	logic [15:0] mode2_reg [AXES]; // Limit, pulse and encoder mode.
	logic [15:0] mode3_reg [AXES]; // Acceleration and output mode.
	logic [AXES-1:0] enc_a_prev_reg; // Previous encoder A level.
	logic [AXES-1:0] enc_b_prev_reg; // Previous encoder B level.
	logic [AXES-1:0] ext_plus_prev_reg; // Previous external plus level.
	logic [AXES-1:0] ext_minus_prev_reg; // Previous external minus level.
	logic [AXES-1:0] busy_prev_reg; // Previous drive busy level.
	logic [AXES-1:0] over_plus; // Compared position above plus value.
	logic [AXES-1:0] under_minus; // Compared position below minus value.
	logic [AXES-1:0] hard_act; // Either hard limit input active.
	logic [AXES-1:0] alarm_act; // Enabled alarm input active.

	// Turns an input pin into an active flag using its polarity bit.
	function automatic logic active_level(input logic pin, input logic pol);
		return pol ? pin : ~pin;
	endfunction : active_level

	// Returns the counter step for one sample of the encoder inputs.
	function automatic logic [POS_W-1:0] enc_step(input logic a,
			input logic b, input logic pa, input logic pb,
			input logic updn, input logic [1:0] div);
		logic ea;
		logic eb;
		logic up;
		logic cnt;
		ea = a ^ pa;
		eb = b ^ pb;
		up = 1'b0;
		cnt = 1'b0;
		if (updn) begin
			// Up/down pulses count on rising edges only; both cancel.
			up = a & ~pa;
			cnt = (a & ~pa) ^ (b & ~pb);
		end else if (ea && !eb) begin
			// An A edge counts up when A now differs from B.
			up = a ^ b;
			cnt = (div == QDIV_1) || (div == QDIV_2) ||
				((div == QDIV_4) && a);
		end else if (eb && !ea) begin
			// A B edge counts up when B now matches A.
			up = ~(a ^ b);
			cnt = (div == QDIV_1);
		end
		if (!cnt) begin
			return '0;
		end else if (up) begin
			return POS_W'(1);
		end
		return '1;
	endfunction : enc_step

	// Remembers which axes the last select command named.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			axis_sel_reg <= AXES'(AXIS_SEL_RESET);
		end else if (axis_select_command) begin
			axis_sel_reg <= sel_axes;
		end
	end

	// Stores mode writes in the copy of every selected axis.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < AXES; i++) begin
				mode2_reg[i] <= MODE_RESET;
				mode3_reg[i] <= MODE_RESET;
			end
		end else if (wr_en) begin
			for (int i = 0; i < AXES; i++) begin
				if (axis_sel_reg[i] && wr_reg_sel == SEL_MODE2) begin
					mode2_reg[i] <= wr_data;
				end else if (axis_sel_reg[i]) begin
					mode3_reg[i] <= wr_data & ~MODE3_ZERO_MASK;
				end
			end
		end
	end

	// Compare results and active input levels per axis.
	always_comb begin
		for (int i = 0; i < AXES; i++) begin
			logic [POS_W-1:0] pos;
			pos = mode2_reg[i][B_COMPARE_SRC] ? real_pos[i] :
				logical_pos[i];
			over_plus[i] = $signed(pos) > $signed(comp_plus[i]);
			under_minus[i] = $signed(pos) < $signed(comp_minus[i]);
			hard_act[i] = active_level(hard_limit_plus_in[i],
				mode2_reg[i][B_HARD_PLUS_POL]) ||
				active_level(hard_limit_minus_in[i],
				mode2_reg[i][B_HARD_MINUS_POL]);
			alarm_act[i] = mode2_reg[i][B_ALARM_EN] &&
				active_level(servo_alarm_in[i],
				mode2_reg[i][B_ALARM_POL]);
		end
	end

	// Encoder sampling and the real position counter.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			enc_a_prev_reg <= '0;
			enc_b_prev_reg <= '0;
			real_pos <= '0;
		end else begin
			enc_a_prev_reg <= encoder_a_in;
			enc_b_prev_reg <= encoder_b_in;
			for (int i = 0; i < AXES; i++) begin
				real_pos[i] <= real_pos[i] + enc_step(encoder_a_in[i],
					encoder_b_in[i], enc_a_prev_reg[i], enc_b_prev_reg[i],
					mode2_reg[i][B_ENC_TYPE],
					mode2_reg[i][B_QDIV_HI:B_QDIV_LO]);
			end
		end
	end

	// Error flags: hardware sets win over a clear in the same cycle.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			soft_limit_plus_flag <= '0;
			soft_limit_minus_flag <= '0;
			alarm_flag <= '0;
		end else begin
			for (int i = 0; i < AXES; i++) begin
				if (mode2_reg[i][B_SOFT_PLUS_EN] && over_plus[i]) begin
					soft_limit_plus_flag[i] <= 1'b1;
				end else if (error_clear || !mode2_reg[i][B_SOFT_PLUS_EN]) begin
					soft_limit_plus_flag[i] <= 1'b0;
				end
				if (mode2_reg[i][B_SOFT_MINUS_EN] && under_minus[i]) begin
					soft_limit_minus_flag[i] <= 1'b1;
				end else if (error_clear || !mode2_reg[i][B_SOFT_MINUS_EN]) begin
					soft_limit_minus_flag[i] <= 1'b0;
				end
				if (alarm_act[i]) begin
					alarm_flag[i] <= 1'b1;
				end else if (error_clear) begin
					alarm_flag[i] <= 1'b0;
				end
			end
		end
	end

	// Passes drive commands on unless that direction's soft limit flag is set.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			drive_start_plus <= '0;
			drive_start_minus <= '0;
		end else begin
			drive_start_plus <= drive_cmd_plus & ~soft_limit_plus_flag;
			drive_start_minus <= drive_cmd_minus & ~soft_limit_minus_flag;
		end
	end

	// Stop requests to the pulse generator while it drives.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			decel_stop <= '0;
			sudden_stop <= '0;
		end else begin
			for (int i = 0; i < AXES; i++) begin
				decel_stop[i] <= drive_busy[i] && (
					(mode2_reg[i][B_SOFT_PLUS_EN] && over_plus[i] &&
					!drive_dir_minus[i]) ||
					(mode2_reg[i][B_SOFT_MINUS_EN] && under_minus[i] &&
					drive_dir_minus[i]) ||
					(hard_act[i] && mode2_reg[i][B_HARD_STOP_TYPE]));
				sudden_stop[i] <= drive_busy[i] && ((hard_act[i] &&
					!mode2_reg[i][B_HARD_STOP_TYPE]) || alarm_act[i]);
			end
		end
	end

	// Drive pulse pin formatting for both output types.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pulse_plus_out <= '0;
			pulse_minus_or_dir_out <= '0;
		end else begin
			for (int i = 0; i < AXES; i++) begin
				if (mode2_reg[i][B_PULSE_TYPE]) begin
					pulse_plus_out[i] <= drive_pulse[i] ^
						mode2_reg[i][B_PULSE_POL];
					pulse_minus_or_dir_out[i] <= drive_dir_minus[i] ^
						mode2_reg[i][B_DIR_POL];
				end else begin
					pulse_plus_out[i] <= (drive_pulse[i] &&
						!drive_dir_minus[i]) ^ mode2_reg[i][B_PULSE_POL];
					pulse_minus_or_dir_out[i] <= (drive_pulse[i] &&
						drive_dir_minus[i]) ^ mode2_reg[i][B_PULSE_POL];
				end
			end
		end
	end

	// Drive status stays set after pulsing until in-position arrives.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_prev_reg <= '0;
			axis_driving_flag <= '0;
		end else begin
			busy_prev_reg <= drive_busy;
			for (int i = 0; i < AXES; i++) begin
				if (drive_busy[i]) begin
					axis_driving_flag[i] <= 1'b1;
				end else if (!mode2_reg[i][B_INPOS_EN] ||
						active_level(in_position_in[i],
						mode2_reg[i][B_INPOS_POL])) begin
					axis_driving_flag[i] <= 1'b0;
				end
			end
		end
	end

	// Profile selections and external input decoding.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			manual_decel_sel <= '0;
			separate_decel_rate_sel <= '0;
			scurve_profile_sel <= '0;
			external_operation_mode <= '0;
			status_output_sel <= '0;
			general_out <= '0;
			ext_plus_prev_reg <= '1;
			ext_cont_plus <= '0;
			ext_cont_minus <= '0;
			ext_fixed_plus <= '0;
			ext_fixed_minus <= '0;
		end else begin
			ext_plus_prev_reg <= external_plus_in;
			for (int i = 0; i < AXES; i++) begin
				logic fall;
				logic rise;
				logic mfall;
				aiamc_ext_e md;
				fall = ext_plus_prev_reg[i] && !external_plus_in[i];
				mfall = ext_minus_prev_reg[i] && !external_minus_in[i];
				rise = !ext_plus_prev_reg[i] && external_plus_in[i];
				md = aiamc_ext_e'(mode3_reg[i][B_EXTOP_HI:B_EXTOP_LO]);
				manual_decel_sel[i] <= mode3_reg[i][B_MANUAL_DECEL];
				separate_decel_rate_sel[i] <= mode3_reg[i][B_SEP_DECEL];
				scurve_profile_sel[i] <= mode3_reg[i][B_SCURVE];
				external_operation_mode[i] <= md;
				status_output_sel[i] <= mode3_reg[i][B_STATUS_OUT_SEL];
				general_out[i] <= mode3_reg[i][B_GPO_HI:B_GPO_LO];
				ext_cont_plus[i] <= 1'b0;
				ext_cont_minus[i] <= 1'b0;
				ext_fixed_plus[i] <= 1'b0;
				ext_fixed_minus[i] <= 1'b0;
				unique case (md)
					AIAMC_EXT_OFF: begin
					end
					AIAMC_EXT_CONT: begin
						ext_cont_plus[i] <= !external_plus_in[i];
						ext_cont_minus[i] <= !external_minus_in[i];
					end
					AIAMC_EXT_FIXED: begin
						ext_fixed_plus[i] <= fall;
						ext_fixed_minus[i] <= mfall;
					end
					AIAMC_EXT_MPG: begin
						// Plus edges start moves only while minus is held low.
						ext_fixed_plus[i] <= rise && !external_minus_in[i];
						ext_fixed_minus[i] <= fall && !external_minus_in[i];
					end
				endcase
			end
		end
	end

	// Samples the external minus pin for its falling edge.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ext_minus_prev_reg <= '1;
		end else begin
			ext_minus_prev_reg <= external_minus_in;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_plus_refused: assert property (soft_limit_plus_flag[2] &&
		drive_cmd_plus[2] |=> !drive_start_plus[2])
		else $error("plus command passed while plus limit set");
	a_minus_refused: assert property (soft_limit_minus_flag[2] &&
		drive_cmd_minus[2] |=> !drive_start_minus[2])
		else $error("minus command passed while minus limit set");
	a_plus_flag_set: assert property (mode2_reg[2][B_SOFT_PLUS_EN] &&
		over_plus[2] |=> soft_limit_plus_flag[2])
		else $error("plus limit flag not set");
	a_hard_sudden: assert property (drive_busy[3] && hard_act[3] &&
		!mode2_reg[3][B_HARD_STOP_TYPE] |=> sudden_stop[3])
		else $error("hard limit did not stop at once");
	a_alarm_stop: assert property (alarm_act[3] && drive_busy[3]
		|=> alarm_flag[3] && sudden_stop[3])
		else $error("alarm did not flag and stop");
	a_two_pulse: assert property (!mode2_reg[0][B_PULSE_TYPE] &&
		!mode2_reg[0][B_PULSE_POL] && drive_dir_minus[0]
		|=> !pulse_plus_out[0])
		else $error("plus pin pulsed while driving minus");
	a_dir_level: assert property (mode2_reg[0][B_PULSE_TYPE]
		|=> pulse_minus_or_dir_out[0] ==
		($past(drive_dir_minus[0]) ^ $past(mode2_reg[0][B_DIR_POL])))
		else $error("direction pin level wrong");
	a_inpos_hold: assert property ($fell(drive_busy[1]) &&
		mode2_reg[1][B_INPOS_EN] && !active_level(in_position_in[1],
		mode2_reg[1][B_INPOS_POL]) |=> axis_driving_flag[1])
		else $error("drive status dropped before in-position");
	a_write_lands: assert property (wr_en && !wr_reg_sel &&
		axis_sel_reg[1] |=> mode2_reg[1] == $past(wr_data))
		else $error("mode write missed a selected axis");
	c_soft_stop: cover property (decel_stop[2] && soft_limit_plus_flag[2]);
	c_inpos_wait: cover property ($fell(drive_busy[1]) ##1
		axis_driving_flag[1]);
	c_enc_count: cover property (real_pos[2] != $past(real_pos[2]));
endmodule : aiamc_axis_mode

`default_nettype wire

// >>> tb/aiamc_drv_model.sv
`default_nettype none

// Motor driver, limit sensors and encoder as seen from the axis pins.
module aiamc_drv_model #(
	parameter int AXES = 4
) (
	input wire logic clock, // System clock.
	input wire logic [AXES-1:0] lim_plus_on, // Plus limit sensor hit.
	input wire logic [AXES-1:0] lim_minus_on, // Minus limit sensor hit.
	input wire logic [AXES-1:0] alarm_on, // Driver reports an alarm.
	input wire logic [AXES-1:0] inpos_on, // Driver has settled.
	output logic [AXES-1:0] hard_limit_plus_in, // Plus limit pin.
	output logic [AXES-1:0] hard_limit_minus_in, // Minus limit pin.
	output logic [AXES-1:0] servo_alarm_in, // Alarm pin.
	output logic [AXES-1:0] in_position_in, // In-position pin.
	output var logic [AXES-1:0] encoder_a_in, // Encoder A or up pin.
	output var logic [AXES-1:0] encoder_b_in // Encoder B or down pin.
);
	timeunit 1ns;
	timeprecision 1ps;
	// Open-collector outputs pull low when active; the pull-up wins otherwise.
	assign hard_limit_plus_in = ~lim_plus_on;
	assign hard_limit_minus_in = ~lim_minus_on;
	assign servo_alarm_in = ~alarm_on;
	assign in_position_in = ~inpos_on;
	// Quadrature states, A leading B forward and B leading A backward.
	localparam logic [7:0] FWD_SEQ = 8'hB4;
	localparam logic [7:0] REV_SEQ = 8'h78;

	// The encoder rests with both pins low.
	initial begin
		encoder_a_in = {AXES{1'b0}};
		encoder_b_in = {AXES{1'b0}};
	end

	// Full encoder cycles; one pin moves at a time so no step is lost.
	task quad(input int ax, input int n, input logic rev);
		logic [7:0] sq;
		sq = rev ? REV_SEQ : FWD_SEQ;
		for (int i = 0; i < n; i++) begin
			for (int s = 0; s < 4; s++) begin
				encoder_a_in[ax] = sq[7-2*s];
				encoder_b_in[ax] = sq[6-2*s];
				repeat (3) @(negedge clock);
			end
		end
	endtask : quad

	// One count pulse on the up pin, or on the down pin when dn is set.
	task ud(input int ax, input logic dn);
		encoder_a_in[ax] = !dn;
		encoder_b_in[ax] = dn;
		repeat (3) @(negedge clock);
		encoder_a_in[ax] = 1'b0;
		encoder_b_in[ax] = 1'b0;
		repeat (3) @(negedge clock);
	endtask : ud
endmodule : aiamc_drv_model

`default_nettype wire

// >>> tb/aiamc_axis_mode_tb.sv
`default_nettype none

// Register-level tests of the per-axis mode block against a driver model.
module aiamc_axis_mode_tb
	import aiamc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rst = 1'b1, axis_select_command = 1'b0;
	logic wr_en = 1'b0, wr_reg_sel = 1'b0, error_clear = 1'b0;
	logic [15:0] wr_data = 16'h0000;
	logic [3:0] sel_axes = 4'h0, drive_busy = 4'h0, drive_dir_minus = 4'h0;
	logic [3:0] drive_pulse = 4'h0, drive_cmd_plus = 4'h0;
	logic [3:0] drive_cmd_minus = 4'h0;
	logic [3:0] external_plus_in = 4'hF, external_minus_in = 4'hF;
	logic [3:0] lim_plus_on = 4'h0, lim_minus_on = 4'h0;
	logic [3:0] alarm_on = 4'h0, inpos_on = 4'h0;
	logic [3:0][31:0] logical_pos = 128'h0, comp_plus = 128'h0;
	logic [3:0][31:0] comp_minus = 128'h0, real_pos;
	logic [3:0] hard_limit_plus_in, hard_limit_minus_in, servo_alarm_in;
	logic [3:0] in_position_in, encoder_a_in, encoder_b_in;
	logic [3:0] pulse_plus_out, pulse_minus_or_dir_out, drive_start_plus;
	logic [3:0] drive_start_minus, decel_stop, sudden_stop, alarm_flag;
	logic [3:0] soft_limit_plus_flag, soft_limit_minus_flag;
	logic [3:0] axis_driving_flag, manual_decel_sel, separate_decel_rate_sel;
	logic [3:0] scurve_profile_sel, status_output_sel, ext_cont_plus;
	logic [3:0] ext_cont_minus, ext_fixed_plus, ext_fixed_minus;
	logic [3:0][1:0] external_operation_mode;
	logic [3:0][3:0] general_out;
	logic [31:0] exp_pos = 32'h0000_0000; // Expected real count of axis 2.
	logic [1:0] st, e; // Command answers and expected pin pairs.
	logic sv; // Pulse seen inside a window.
	int miscompares = 0, n_checks = 0, k;

	// System clock of 100 MHz.
	always #5 clock = ~clock;

	aiamc_axis_mode uut (.clock, .rst, .axis_select_command, .sel_axes,
		.wr_en, .wr_reg_sel, .wr_data, .error_clear, .logical_pos,
		.comp_plus, .comp_minus, .drive_busy, .drive_dir_minus, .drive_pulse,
		.drive_cmd_plus, .drive_cmd_minus, .hard_limit_plus_in,
		.hard_limit_minus_in, .servo_alarm_in, .in_position_in,
		.encoder_a_in, .encoder_b_in, .external_plus_in, .external_minus_in,
		.pulse_plus_out, .pulse_minus_or_dir_out, .real_pos,
		.drive_start_plus, .drive_start_minus, .decel_stop, .sudden_stop,
		.soft_limit_plus_flag, .soft_limit_minus_flag, .alarm_flag,
		.axis_driving_flag, .manual_decel_sel, .separate_decel_rate_sel,
		.scurve_profile_sel, .external_operation_mode, .status_output_sel,
		.general_out, .ext_cont_plus, .ext_cont_minus, .ext_fixed_plus,
		.ext_fixed_minus);

	aiamc_drv_model drv (.clock, .lim_plus_on, .lim_minus_on, .alarm_on,
		.inpos_on, .hard_limit_plus_in, .hard_limit_minus_in,
		.servo_alarm_in, .in_position_in, .encoder_a_in, .encoder_b_in);

	// Compares one value and reports a mismatch at once.
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Lets registered status outputs follow their inputs.
	task settle;
		repeat (3) @(negedge clock);
	endtask : settle

	// Names the axes that later writes land in.
	task sel(input logic [3:0] a);
		@(negedge clock);
		axis_select_command = 1'b1;
		sel_axes = a;
		@(negedge clock);
		axis_select_command = 1'b0;
	endtask : sel

	// Writes one mode register word, then waits for the field outputs.
	task wr(input logic r, input logic [15:0] d);
		@(negedge clock);
		wr_en = 1'b1;
		wr_reg_sel = r;
		wr_data = d;
		@(negedge clock);
		wr_en = 1'b0;
		repeat (2) @(negedge clock);
	endtask : wr

	// Issues a one-cycle drive command and returns the start pulses.
	task cmd(input int ax, input logic mn, output logic [1:0] s);
		@(negedge clock);
		drive_cmd_plus[ax] = !mn;
		drive_cmd_minus[ax] = mn;
		@(negedge clock);
		s = {drive_start_plus[ax], drive_start_minus[ax]};
		drive_cmd_plus = 4'h0;
		drive_cmd_minus = 4'h0;
	endtask : cmd

	// Sets the sensors of axis 3, writes its mode and reads the stops.
	task stop_case(input logic [15:0] d, input logic [2:0] p,
		input logic [2:0] x);
		lim_plus_on[3] = p[2];
		lim_minus_on[3] = p[1];
		alarm_on[3] = p[0];
		wr(SEL_MODE2, d);
		settle;
		check({alarm_flag[3], sudden_stop[3], decel_stop[3]}, x);
	endtask : stop_case

	// Prints the counts and the verdict, then ends the run.
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	// Cuts a hang short well beyond the expected length of the run.
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		test_done;
	end

	// Main test sequence.
	initial begin
		repeat (5) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		check({general_out, external_operation_mode, manual_decel_sel,
			separate_decel_rate_sel}, 32'h0000_0000);
		check({scurve_profile_sel, status_output_sel, pulse_plus_out,
			pulse_minus_or_dir_out}, 32'h0000_0000);
		$display("test reset done");
		// Deceleration, rate and S-curve selections each follow their own written bit on the selected axes.
		sel(4'h2);
		wr(SEL_MODE3, 16'hFFFF);
		check({manual_decel_sel, separate_decel_rate_sel, scurve_profile_sel,
			status_output_sel}, 32'h0000_2222);
		check({general_out, external_operation_mode}, 32'h0000_F00C);
		wr(SEL_MODE3, 16'h0000);
		check({manual_decel_sel, scurve_profile_sel}, 32'h0000_0000);
		sel(4'h9);
		wr(SEL_MODE3, 16'h0005);
		check({manual_decel_sel, separate_decel_rate_sel,
			scurve_profile_sel}, 32'h0000_0909);
		sel(4'h1);
		for (int m = 0; m < 4; m++) begin
			wr(SEL_MODE3, 16'(m) << 3);
			check(external_operation_mode[0], m);
		end
		wr(SEL_MODE3, 16'h0008);
		external_plus_in[0] = 1'b0;
		settle;
		check({ext_cont_plus[0], ext_cont_minus[0]}, 2'b10);
		external_plus_in[0] = 1'b1;
		wr(SEL_MODE3, 16'h0010);
		external_minus_in[0] = 1'b0;
		sv = 1'b0;
		repeat (4) begin
			@(negedge clock);
			sv = sv | ext_fixed_minus[0];
		end
		check(sv, 1'b1);
		// Hand wheel mode with minus held low: plus edges start moves.
		wr(SEL_MODE3, 16'h0018);
		external_plus_in[0] = 1'b0;
		@(negedge clock);
		check({ext_fixed_plus[0], ext_fixed_minus[0]}, 2'b01);
		external_plus_in[0] = 1'b1;
		@(negedge clock);
		check({ext_fixed_plus[0], ext_fixed_minus[0]}, 2'b10);
		external_minus_in[0] = 1'b1;
		$display("test accel mode done");
		// Every pulse type, pulse polarity, direction polarity and direction.
		for (int i = 0; i < 16; i++) begin
			wr(SEL_MODE2, {7'h00, i[2], i[1], i[0], 6'h00});
			drive_dir_minus[0] = i[3];
			for (int p = 1; p >= 0; p--) begin
				drive_pulse[0] = p[0];
				if (!i[0]) e = {(p[0] & ~i[3]) ^ i[1], (p[0] & i[3]) ^ i[1]};
				else e = {p[0] ^ i[1], i[3] ^ i[2]};
				settle;
				check({pulse_plus_out[0], pulse_minus_or_dir_out[0]}, e);
			end
		end
		$display("test pulse format done");
		// Every division code, forwards then backwards, then up/down input.
		sel(4'h4);
		for (int d = 0; d < 4; d++) begin
			k = (d == 0) ? 4 : (d == 1) ? 2 : (d == 2) ? 1 : 0;
			wr(SEL_MODE2, 16'(d) << 10);
			drv.quad(2, 2, 1'b0);
			exp_pos = exp_pos + 32'(2 * k);
			check(real_pos[2], exp_pos);
			drv.quad(2, 1, 1'b1);
			exp_pos = exp_pos - 32'(k);
			check(real_pos[2], exp_pos);
		end
		wr(SEL_MODE2, 16'h0A00);
		repeat (3) drv.ud(2, 1'b0);
		drv.ud(2, 1'b1);
		check(real_pos[2], exp_pos + 32'h0000_0002);
		$display("test encoder done");
		// Soft limits of axis 2, compared first against the logical, then the real counter.
		comp_plus[2] = 32'h0000_0005;
		comp_minus[2] = 32'h0000_0014;
		drive_busy[2] = 1'b1;
		wr(SEL_MODE2, 16'h0001);
		settle;
		check({soft_limit_plus_flag[2], decel_stop[2]}, 2'b00);
		wr(SEL_MODE2, 16'h0021);
		settle;
		check({soft_limit_plus_flag[2], decel_stop[2]}, 2'b11);
		cmd(2, 1'b0, st);
		check(st, 2'b00);
		cmd(2, 1'b1, st);
		check(st, 2'b01);
		drive_dir_minus[2] = 1'b1;
		wr(SEL_MODE2, 16'h0022);
		settle;
		check({soft_limit_minus_flag[2], decel_stop[2]}, 2'b11);
		cmd(2, 1'b1, st);
		check(st, 2'b00);
		cmd(2, 1'b0, st);
		check(st, 2'b10);
		wr(SEL_MODE2, 16'h0000);
		drive_busy[2] = 1'b0;
		$display("test soft limit done");
		// Hard limits and servo alarm of axis 3 while it drives.
		sel(4'h8);
		drive_busy[3] = 1'b1;
		stop_case(16'h0000, 3'b000, 3'b000);
		stop_case(16'h0000, 3'b010, 3'b010);
		stop_case(16'h0004, 3'b100, 3'b001);
		stop_case(16'h0008, 3'b000, 3'b010);
		stop_case(16'h0010, 3'b000, 3'b010);
		stop_case(16'h0018, 3'b110, 3'b000);
		stop_case(16'h0000, 3'b001, 3'b000);
		stop_case(16'h2000, 3'b001, 3'b110);
		alarm_on[3] = 1'b0;
		wr(SEL_MODE2, 16'h0000);
		error_clear = 1'b1;
		@(negedge clock);
		error_clear = 1'b0;
		settle;
		check(alarm_flag[3], 1'b0);
		drive_busy[3] = 1'b0;
		$display("test stops done");
		// In-position holds the drive status of axis 1 until it arrives.
		sel(4'h2);
		wr(SEL_MODE2, 16'h8000);
		drive_busy[1] = 1'b1;
		settle;
		check(axis_driving_flag[1], 1'b1);
		drive_busy[1] = 1'b0;
		settle;
		check(axis_driving_flag[1], 1'b1);
		inpos_on[1] = 1'b1;
		settle;
		check(axis_driving_flag[1], 1'b0);
		inpos_on[1] = 1'b0;
		wr(SEL_MODE2, 16'h0000);
		drive_busy[1] = 1'b1;
		settle;
		drive_busy[1] = 1'b0;
		settle;
		check(axis_driving_flag[1], 1'b0);
		$display("test in position done");
		test_done;
	end
endmodule : aiamc_axis_mode_tb

`default_nettype wire
